// *** design/cfbs_array_port.v ***
// Array operation port: launches one operation on the flash array and
// waits for its completion or a timeout.
// Assumes the array answers on the same clock with a done pulse.
`timescale 1ns/1ps
`include "cfbs_map.vh"

module cfbs_array_port #(
    parameter TIMEOUT_CYC = `CFBS_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // Request from sequencer
    input  wire        start_in,
    input  wire [1:0]  cmd_in,
    input  wire [19:0] addr_in,
    input  wire [31:0] data_in,
    output reg         done_out,
    output reg         fail_out,
    // Flash array side
    output reg         arr_go_out,
    output reg  [1:0]  arr_cmd_out,
    output reg  [19:0] arr_addr_out,
    output reg  [31:0] arr_wdata_out,
    input  wire        arr_done_in,
    input  wire        arr_fail_in
);

    reg        waiting;
    reg [31:0] timer;

    // Launch, wait for the array, bound the wait with a timeout
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            waiting       <= 1'b0;
            timer         <= 32'h0000_0000;
            done_out      <= 1'b0;
            fail_out      <= 1'b0;
            arr_go_out    <= 1'b0;
            arr_cmd_out   <= 2'h0;
            arr_addr_out  <= 20'h0_0000;
            arr_wdata_out <= 32'h0000_0000;
        end else begin
            done_out   <= 1'b0;
            fail_out   <= 1'b0;
            arr_go_out <= 1'b0;
            if (!waiting && start_in) begin
                waiting       <= 1'b1;
                timer         <= 32'h0000_0000;
                arr_go_out    <= 1'b1;
                arr_cmd_out   <= cmd_in;
                arr_addr_out  <= addr_in;
                arr_wdata_out <= data_in;
            end else if (waiting) begin
                timer <= timer + 32'h0000_0001;
                if (arr_done_in) begin
                    waiting  <= 1'b0;
                    done_out <= 1'b1;
                    fail_out <= arr_fail_in;
                end else if (timer == TIMEOUT_CYC - 1) begin
                    waiting  <= 1'b0; // Array never answered
                    done_out <= 1'b1;
                    fail_out <= 1'b1;
                end
            end
        end
    end

endmodule // cfbs_array_port

// *** design/cfbs_map.vh ***
// Register offsets, field positions, reset values and timing counts
// for the code flash boot swap sequencer.
// Assumes a 50 MHz system clock and a 20-bit byte address space.
`ifndef CFBS_MAP_VH
`define CFBS_MAP_VH

// Register byte offsets
`define CFBS_OFS_CTRL      12'h000
`define CFBS_OFS_ADDR      12'h004
`define CFBS_OFS_WDATA     12'h008
`define CFBS_OFS_STATUS    12'h00c
`define CFBS_OFS_IRQ_STAT  12'h010
`define CFBS_OFS_IRQ_MASK  12'h014
`define CFBS_OFS_SECURITY  12'h018
`define CFBS_OFS_WINDOW    12'h01c

// Control register fields
`define CFBS_CTRL_GO       0
`define CFBS_CTRL_CMD_LO   1
`define CFBS_CTRL_CMD_HI   2
`define CFBS_CTRL_SELF     3

// Commands
`define CFBS_CMD_ERASE     2'h0
`define CFBS_CMD_PROG      2'h1
`define CFBS_CMD_VERIFY    2'h2
`define CFBS_CMD_SECURITY  2'h3

// Security flag fields
`define CFBS_SEC_ERASE     0
`define CFBS_SEC_PROG      1
`define CFBS_SEC_BOOT      2
`define CFBS_SEC_SWAP      3
`define CFBS_SEC_WIDTH     4
`define CFBS_SEC_RST       4'h7

// Interrupt status fields
`define CFBS_IRQ_DONE      0
`define CFBS_IRQ_ERR       1
`define CFBS_IRQ_BUSYREJ   2
`define CFBS_IRQ_WIDTH     3

// Window register fields and reset value
`define CFBS_WIN_START_LO  0
`define CFBS_WIN_END_LO    16
`define CFBS_WIN_RST       32'h03ff_0000

// Geometry
`define CFBS_BLOCK_BITS    10
`define CFBS_WORD_BITS     2
`define CFBS_CLUSTER_BIT   12
`define CFBS_BOOT_TOP_LO   13

// Array timeout: time in microseconds and derived cycle count at 50 MHz
`define CFBS_CLK_MHZ       50
`define CFBS_TIMEOUT_US    1000
`define CFBS_TIMEOUT_CYC   (`CFBS_TIMEOUT_US * `CFBS_CLK_MHZ)

`endif

// *** design/cfbs_sequencer.v ***
// Code flash sequencer: APB registers, protection and shield window
// checks, erase/program/verify/security operations, fetch blocking and
// boot cluster swap on the fetch path.
// Assumes the CPU fetch port and flash array run on sys_clk_in.
`timescale 1ns/1ps
`include "cfbs_map.vh"

module cfbs_sequencer #(
    parameter TIMEOUT_CYC = `CFBS_TIMEOUT_CYC
) (
    // Clock and reset
    input  wire        sys_clk_in,
    input  wire        rst_n_in,
    // APB slave
    input  wire        psel_in,
    input  wire        penable_in,
    input  wire        pwrite_in,
    input  wire [11:0] paddr_in,
    input  wire [31:0] pwdata_in,
    output reg  [31:0] prdata_out,
    output reg         pready_out,
    output reg         pslverr_out,
    // Interrupt
    output reg         irq_out,
    // CPU fetch port
    input  wire        fetch_req_in,
    input  wire [19:0] fetch_addr_in,
    output reg         fetch_stall_out,
    output reg         rd_en_out,
    output reg  [19:0] rd_addr_out,
    // Stored security flags read from the array
    input  wire [3:0]  nv_flags_in,
    // Flash array operation side
    output wire        arr_go_out,
    output wire [1:0]  arr_cmd_out,
    output wire [19:0] arr_addr_out,
    output wire [31:0] arr_wdata_out,
    input  wire        arr_done_in,
    input  wire        arr_fail_in,
    // Status
    output reg         busy_out
);

    localparam ST_LOAD = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_RUN  = 2'h2;

    // True for addresses inside the two boot clusters
    function in_boot;
        input [19:0] a;
        begin
            in_boot = (a[19:`CFBS_BOOT_TOP_LO] == 7'h00);
        end
    endfunction

    reg  [1:0]  state;
    reg  [1:0]  next_state;
    reg  [1:0]  cmd;
    reg         self_prog;
    reg  [19:0] addr;
    reg  [31:0] wdata;
    reg  [3:0]  sec;
    reg         swap_live;
    reg  [31:0] window;
    reg  [2:0]  irq_stat;
    reg  [2:0]  irq_mask;
    reg  [1:0]  run_cmd;
    reg  [31:0] run_data;
    reg         port_start;
    reg  [19:0] port_addr;

    wire        port_done;
    wire        port_fail;

    // APB decode
    wire        apb_acc  = psel_in & penable_in & ~pready_out;
    wire        apb_wr   = apb_acc & pwrite_in;
    wire        ofs_ok   = (paddr_in[1:0] == 2'h0) && (paddr_in <= `CFBS_OFS_WINDOW);
    wire        wr_ctrl  = apb_wr && ofs_ok && (paddr_in == `CFBS_OFS_CTRL);
    wire        go       = wr_ctrl & pwdata_in[`CFBS_CTRL_GO];
    wire [1:0]  go_cmd   = pwdata_in[`CFBS_CTRL_CMD_HI:`CFBS_CTRL_CMD_LO];
    wire        go_self  = pwdata_in[`CFBS_CTRL_SELF];

    // Block and window limits
    wire [9:0]  blk      = addr[19:`CFBS_BLOCK_BITS];
    wire [9:0]  win_lo   = window[`CFBS_WIN_START_LO +: 10];
    wire [9:0]  win_hi   = window[`CFBS_WIN_END_LO +: 10];
    wire        out_win  = (blk < win_lo) || (blk > win_hi);
    wire        modify   = (go_cmd == `CFBS_CMD_ERASE) || (go_cmd == `CFBS_CMD_PROG);

    // Refusal decision for a new request
    reg         refuse;
    always @* begin
        refuse = 1'b0;
        if (go_self) begin
            refuse = modify & out_win;
        end else begin
            if (go_cmd == `CFBS_CMD_ERASE && sec[`CFBS_SEC_ERASE])
                refuse = 1'b1;
            if (go_cmd == `CFBS_CMD_PROG && sec[`CFBS_SEC_PROG])
                refuse = 1'b1;
            if (modify && sec[`CFBS_SEC_BOOT] && in_boot(addr))
                refuse = 1'b1;
            if (go_cmd == `CFBS_CMD_SECURITY)
                refuse = 1'b1;
        end
    end

    wire accept = go && (state == ST_IDLE) && !refuse;

    // Target address rounded to the operation unit
    always @* begin
        case (go_cmd)
            `CFBS_CMD_ERASE,
            `CFBS_CMD_VERIFY: port_addr = {addr[19:`CFBS_BLOCK_BITS], 10'h000};
            `CFBS_CMD_PROG:   port_addr = {addr[19:`CFBS_WORD_BITS], 2'h0};
            default:          port_addr = 20'h0_0000;
        endcase
    end

    // Next state of the sequencer
    always @* begin
        next_state = state;
        case (state)
            ST_LOAD: next_state = ST_IDLE;
            ST_IDLE: if (accept) next_state = ST_RUN;
            ST_RUN:  if (port_done) next_state = ST_IDLE;
            default: next_state = ST_IDLE;
        endcase
    end

    // Sequencer state, security flags and command capture
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            state      <= ST_LOAD;
            sec        <= `CFBS_SEC_RST;
            swap_live  <= 1'b0;
            cmd        <= 2'h0;
            self_prog  <= 1'b0;
            run_cmd    <= 2'h0;
            run_data   <= 32'h0000_0000;
            port_start <= 1'b0;
        end else begin
            state      <= next_state;
            port_start <= accept;
            if (state == ST_LOAD) begin
                sec       <= nv_flags_in;                 // Flags held in the array
                swap_live <= nv_flags_in[`CFBS_SEC_SWAP];
            end
            if (wr_ctrl) begin
                cmd       <= go_cmd;
                self_prog <= go_self;
            end
            if (accept) begin
                run_cmd  <= go_cmd;
                run_data <= wdata;
            end
            // New flags stored; the swap itself waits for the next reset
            if (state == ST_RUN && port_done && !port_fail &&
                run_cmd == `CFBS_CMD_SECURITY)
                sec <= run_data[`CFBS_SEC_WIDTH-1:0];
        end
    end

    reg [19:0] run_addr;
    always @(posedge sys_clk_in) begin
        if (!rst_n_in)
            run_addr <= 20'h0_0000;
        else if (accept)
            run_addr <= port_addr;
    end

    // Array operation launcher
    cfbs_array_port #(
        .TIMEOUT_CYC (TIMEOUT_CYC)
    ) u_port (
        .sys_clk_in    (sys_clk_in),
        .rst_n_in      (rst_n_in),
        .start_in      (port_start),
        .cmd_in        (run_cmd),
        .addr_in       (run_addr),
        .data_in       (run_data),
        .done_out      (port_done),
        .fail_out      (port_fail),
        .arr_go_out    (arr_go_out),
        .arr_cmd_out   (arr_cmd_out),
        .arr_addr_out  (arr_addr_out),
        .arr_wdata_out (arr_wdata_out),
        .arr_done_in   (arr_done_in),
        .arr_fail_in   (arr_fail_in)
    );

    // Software-written registers
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            addr     <= 20'h0_0000;
            wdata    <= 32'h0000_0000;
            window   <= `CFBS_WIN_RST;
            irq_mask <= 3'h0;
        end else if (apb_wr && ofs_ok) begin
            case (paddr_in)
                `CFBS_OFS_ADDR:     addr     <= pwdata_in[19:0];
                `CFBS_OFS_WDATA:    wdata    <= pwdata_in;
                `CFBS_OFS_WINDOW:   window   <= pwdata_in & 32'h03ff_03ff;
                `CFBS_OFS_IRQ_MASK: irq_mask <= pwdata_in[2:0];
                default:            addr     <= addr;
            endcase
        end
    end

    // Sticky event flags, write one to clear, set wins over clear
    wire [2:0] ev_set;
    wire [2:0] ev_clr = (apb_wr && paddr_in == `CFBS_OFS_IRQ_STAT) ?
                        pwdata_in[2:0] : 3'h0;
    assign ev_set[`CFBS_IRQ_DONE]    = (state == ST_RUN) & port_done & ~port_fail;
    assign ev_set[`CFBS_IRQ_ERR]     = (go & (state == ST_IDLE) & refuse) |
                                       ((state == ST_RUN) & port_done & port_fail);
    assign ev_set[`CFBS_IRQ_BUSYREJ] = go & (state != ST_IDLE);

    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            irq_stat <= 3'h0;
            irq_out  <= 1'b0;
        end else begin
            irq_stat <= (irq_stat & ~ev_clr) | ev_set;
            irq_out  <= |(((irq_stat & ~ev_clr) | ev_set) & irq_mask);
        end
    end

    // Fetch path: blocked while busy, boot clusters swapped when live
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            busy_out        <= 1'b0;
            fetch_stall_out <= 1'b0;
            rd_en_out       <= 1'b0;
            rd_addr_out     <= 20'h0_0000;
        end else begin
            busy_out        <= (next_state != ST_IDLE);
            fetch_stall_out <= fetch_req_in & (next_state != ST_IDLE);
            rd_en_out       <= fetch_req_in & (next_state == ST_IDLE);
            if (swap_live && in_boot(fetch_addr_in))
                rd_addr_out <= fetch_addr_in ^ 20'h0_1000;
            else
                rd_addr_out <= fetch_addr_in;
        end
    end

    // APB answer: one wait cycle, read data and error registered
    always @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pready_out  <= 1'b0;
            pslverr_out <= 1'b0;
            prdata_out  <= 32'h0000_0000;
        end else begin
            pready_out  <= apb_acc;
            pslverr_out <= apb_acc & ~ofs_ok;
            prdata_out  <= 32'h0000_0000;
            if (apb_acc && !pwrite_in && ofs_ok) begin
                case (paddr_in)
                    `CFBS_OFS_CTRL:     prdata_out <= {28'h0, self_prog, cmd, 1'b0};
                    `CFBS_OFS_ADDR:     prdata_out <= {12'h000, addr};
                    `CFBS_OFS_WDATA:    prdata_out <= wdata;
                    `CFBS_OFS_STATUS:   prdata_out <= {29'h0, swap_live, irq_stat[1],
                                                       state != ST_IDLE};
                    `CFBS_OFS_IRQ_STAT: prdata_out <= {29'h0, irq_stat};
                    `CFBS_OFS_IRQ_MASK: prdata_out <= {29'h0, irq_mask};
                    `CFBS_OFS_SECURITY: prdata_out <= {28'h0, sec};
                    `CFBS_OFS_WINDOW:   prdata_out <= window;
                    default:            prdata_out <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule // cfbs_sequencer

// *** sim/cfbs_array_model.sv ***
// Behavioural flash array: answers each launch after a short or long delay.
// Assumes the sequencer clock; stored flags survive a sequencer reset.
`timescale 1ns/1ps
`include "cfbs_map.vh"

module cfbs_array_model (
    // Clock and test controls
    input  wire        sys_clk_in,
    input  wire        slow_in,
    input  wire        fail_in,
    // Operation from the sequencer
    input  wire        go_in,
    input  wire [1:0]  cmd_in,
    input  wire [19:0] addr_in,
    input  wire [31:0] wdata_in,
    // Answer and observation
    output reg         done_out = 1'b0,
    output wire        fail_out,
    output reg  [3:0]  nv_flags_out = 4'h7, // Erased flags: all protections on
    output reg  [31:0] n_ops_out = 32'h0,
    output reg  [19:0] last_addr_out = 20'h0,
    output reg  [31:0] last_data_out = 32'h0
);
    reg [4:0] cnt = 5'h00;
    reg       run = 1'b0;
    reg       fail_q = 1'b0;
    reg       junk = 1'b0;
    reg [1:0] cmd_q = 2'h0;
    reg [3:0] sec_q = 4'h0;

    // Fail is only meaningful with done; otherwise it toggles
    assign fail_out = done_out ? fail_q : junk;

    // Operation timing and flag storage
    always @(posedge sys_clk_in) begin
        done_out <= 1'b0;
        junk <= ~junk;
        if (go_in) begin
            run <= 1'b1;
            cnt <= slow_in ? 5'd12 : 5'd2;
            cmd_q <= cmd_in;
            sec_q <= wdata_in[3:0];
            fail_q <= fail_in;
            n_ops_out <= n_ops_out + 32'h1;
            last_addr_out <= addr_in;
            last_data_out <= wdata_in;
        end else if (run) begin
            cnt <= cnt - 5'd1;
            if (cnt == 5'd1) begin
                run <= 1'b0;
                done_out <= 1'b1;
                if (cmd_q == `CFBS_CMD_SECURITY && !fail_q) nv_flags_out <= sec_q;
            end
        end
    end
endmodule // cfbs_array_model

// *** sim/cfbs_seq_props.sv ***
// Checker for the flash sequencer: array launch, fetch blocking, cluster map.
// Assumes one clock; bound to every cfbs_sequencer below.
`timescale 1ns/1ps
`include "cfbs_map.vh"

module cfbs_seq_props (
    // Clock and reset
    input wire        sys_clk_in,
    input wire        rst_n_in,
    // Fetch port
    input wire        fetch_req_in,
    input wire [19:0] fetch_addr_in,
    input wire        fetch_stall_out,
    input wire        rd_en_out,
    input wire [19:0] rd_addr_out,
    // Array side and status
    input wire        arr_go_out,
    input wire [1:0]  arr_cmd_out,
    input wire [19:0] arr_addr_out,
    input wire        arr_done_in,
    input wire        busy_out
);
    reg [19:0] last_fetch;

    default clocking cb_sys @(posedge sys_clk_in); endclocking
    default disable iff (!rst_n_in);

    // Fetch address of the previous cycle
    always @(posedge sys_clk_in) last_fetch <= fetch_addr_in;

    erase_whole_block_a: assert property (
        arr_go_out && (arr_cmd_out == `CFBS_CMD_ERASE || arr_cmd_out == `CFBS_CMD_VERIFY)
        |-> arr_addr_out[9:0] == 10'h000) else $error("erase or verify not block aligned");
    prog_one_word_a: assert property (
        arr_go_out && arr_cmd_out == `CFBS_CMD_PROG |-> arr_addr_out[1:0] == 2'b00)
        else $error("program not word aligned");
    busy_covers_go_a: assert property (
        arr_go_out |-> busy_out && $past(busy_out)) else $error("array launched while idle");
    go_single_a: assert property (
        arr_go_out |=> !arr_go_out [*2]) else $error("array launch repeated");
    done_idle_a: assert property (
        busy_out && arr_done_in |-> ##2 !busy_out) else $error("busy held after completion");
    fetch_block_a: assert property (
        fetch_req_in |=> (fetch_stall_out == busy_out) && (rd_en_out == !busy_out))
        else $error("flash read while busy");
    fetch_read_a: assert property (
        !busy_out && fetch_req_in && fetch_addr_in[19:13] != 7'h00
        |=> rd_en_out && rd_addr_out == last_fetch) else $error("plain fetch wrong");
    cluster_map_a: assert property (
        !busy_out && fetch_req_in && fetch_addr_in[19:13] == 7'h00 |=> rd_en_out
        && rd_addr_out[19:13] == 7'h00 && rd_addr_out[11:0] == last_fetch[11:0])
        else $error("boot cluster fetch wrong");
endmodule // cfbs_seq_props

bind cfbs_sequencer cfbs_seq_props i_props (
    .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .fetch_req_in(fetch_req_in),
    .fetch_addr_in(fetch_addr_in), .fetch_stall_out(fetch_stall_out), .rd_en_out(rd_en_out),
    .rd_addr_out(rd_addr_out), .arr_go_out(arr_go_out), .arr_cmd_out(arr_cmd_out),
    .arr_addr_out(arr_addr_out), .arr_done_in(arr_done_in), .busy_out(busy_out));

// *** sim/cfbs_tb.sv ***
// Testbench for the flash sequencer over APB with an array model.
// Assumes the bound checker and a 50 MHz clock.
`timescale 1ns/1ps
`include "cfbs_map.vh"

module testbench;
    logic        sys_clk_in = 1'b0, rst_n_in = 1'b0, slow = 1'b0, fail_ctl = 1'b0;
    logic        psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, fetch_req_in = 1'b0;
    logic [11:0] paddr_in = 12'h000;
    logic [31:0] pwdata_in = 32'h0;
    logic [19:0] fetch_addr_in = 20'h0;
    wire  [31:0] prdata_out, arr_wdata_out, n_ops, last_data;
    wire  [19:0] rd_addr_out, arr_addr_out, last_addr;
    wire  [3:0]  nv_flags;
    wire  [1:0]  arr_cmd_out;
    wire         pready_out, pslverr_out, irq_out, fetch_stall_out, rd_en_out, busy_out;
    wire         arr_go_out, arr_done_in, arr_fail_in;
    int          n_fail = 0, cmp_count = 0;

    always #10 sys_clk_in = ~sys_clk_in;

    cfbs_sequencer #(.TIMEOUT_CYC(20)) i_dut (
        .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .psel_in(psel_in),
        .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
        .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
        .pslverr_out(pslverr_out), .irq_out(irq_out), .fetch_req_in(fetch_req_in),
        .fetch_addr_in(fetch_addr_in), .fetch_stall_out(fetch_stall_out),
        .rd_en_out(rd_en_out), .rd_addr_out(rd_addr_out), .nv_flags_in(nv_flags),
        .arr_go_out(arr_go_out), .arr_cmd_out(arr_cmd_out), .arr_addr_out(arr_addr_out),
        .arr_wdata_out(arr_wdata_out), .arr_done_in(arr_done_in),
        .arr_fail_in(arr_fail_in), .busy_out(busy_out));

    cfbs_array_model i_array (
        .sys_clk_in(sys_clk_in), .slow_in(slow), .fail_in(fail_ctl), .go_in(arr_go_out),
        .cmd_in(arr_cmd_out), .addr_in(arr_addr_out), .wdata_in(arr_wdata_out),
        .done_out(arr_done_in), .fail_out(arr_fail_in), .nv_flags_out(nv_flags),
        .n_ops_out(n_ops), .last_addr_out(last_addr), .last_data_out(last_data));

    // Compare and count
    task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge sys_clk_in);
        psel_in <= 1'b1;
        pwrite_in <= wr;
        paddr_in <= a;
        pwdata_in <= d;
        @(posedge sys_clk_in);
        penable_in <= 1'b1;
        do begin
            @(posedge sys_clk_in);
            n++;
        end while (pready_out !== 1'b1 && n < 50);
        if (n >= 50) n_fail++;
        q = prdata_out;
        e = pslverr_out;
        psel_in <= 1'b0;
        penable_in <= 1'b0;
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic        e;
        apb(1'b1, a, d, q, e);
    endtask

    task automatic rd(input string what, input logic [11:0] a, input logic [31:0] exp,
                      input logic err_exp);
        logic [31:0] q;
        logic        e;
        apb(1'b0, a, 32'h0, q, e);
        chk(what, q, exp);
        chk("slave error", {31'h0, e}, {31'h0, err_exp});
    endtask

    task automatic go(input logic [1:0] c, input logic s, input logic [19:0] a,
                      input logic [31:0] d);
        wr(`CFBS_OFS_ADDR, {12'h000, a});
        wr(`CFBS_OFS_WDATA, d);
        wr(`CFBS_OFS_CTRL, {28'h0, s, c, 1'b1});
    endtask

    // Wait for completion, check and clear the event bits
    task automatic fin(input logic [2:0] irq_exp);
        int n;
        n = 0;
        while (busy_out !== 1'b0 && n < 100) begin
            @(posedge sys_clk_in);
            n++;
        end
        if (n >= 100) n_fail++;
        repeat (2) @(posedge sys_clk_in);
        rd("event bits", `CFBS_OFS_IRQ_STAT, {29'h0, irq_exp}, 1'b0);
        chk("irq line", {31'h0, irq_out}, {31'h0, |irq_exp});
        wr(`CFBS_OFS_IRQ_STAT, 32'h7);
        repeat (2) @(posedge sys_clk_in);
        chk("irq cleared", {31'h0, irq_out}, 32'h0);
    endtask

    task automatic fetch(input logic [19:0] a, input logic [19:0] exp, input logic busy);
        @(posedge sys_clk_in);
        fetch_req_in <= 1'b1;
        fetch_addr_in <= a;
        @(posedge sys_clk_in);
        fetch_req_in <= 1'b0;
        @(posedge sys_clk_in);
        chk("fetch stall", {31'h0, fetch_stall_out}, {31'h0, busy});
        if (!busy) chk("fetch addr", {12'h0, rd_addr_out}, {12'h0, exp});
    endtask

    task automatic do_reset;
        rst_n_in <= 1'b0;
        repeat (8) @(posedge sys_clk_in);
        rst_n_in <= 1'b1;
        repeat (3) @(posedge sys_clk_in);
        wr(`CFBS_OFS_IRQ_MASK, 32'h7);
    endtask

    task automatic stop_test;
        $display("TB: compares %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Watchdog
    initial begin
        repeat (20000) @(posedge sys_clk_in);
        n_fail++;
        stop_test;
    end

    initial begin
        do_reset;
        rd("security", `CFBS_OFS_SECURITY, 32'h7, 1'b0);
        rd("window", `CFBS_OFS_WINDOW, `CFBS_WIN_RST, 1'b0);
        rd("unmapped", 12'h020, 32'h0, 1'b1);
        $display("TB: reset values done");
        for (int c = 0; c < 4; c++) begin
            go(c[1:0], 1'b0, 20'h05555, 32'h0);
            fin((c == 2) ? 3'h1 : 3'h2);
        end
        chk("array ops", n_ops, 32'h1);
        chk("verify addr", {12'h0, last_addr}, 32'h05400);
        go(`CFBS_CMD_ERASE, 1'b1, 20'h00abc, 32'h0);
        fin(3'h1);
        chk("erase addr", {12'h0, last_addr}, 32'h00800);
        go(`CFBS_CMD_PROG, 1'b1, 20'h01237, 32'ha5a5_5a5a);
        fin(3'h1);
        chk("prog addr", {12'h0, last_addr}, 32'h01234);
        chk("prog data", last_data, 32'ha5a5_5a5a);
        $display("TB: protection tests done");
        slow <= 1'b1;
        go(`CFBS_CMD_ERASE, 1'b1, 20'h03000, 32'h0);
        wr(`CFBS_OFS_CTRL, 32'h0000_0009);
        fetch(20'h03000, 20'h0, 1'b1);
        rd("status busy", `CFBS_OFS_STATUS, 32'h1, 1'b0);
        fin(3'h5);
        slow <= 1'b0;
        fail_ctl <= 1'b1;
        go(`CFBS_CMD_ERASE, 1'b1, 20'h02000, 32'h0);
        fin(3'h2);
        fail_ctl <= 1'b0;
        $display("TB: busy and fault tests done");
        go(`CFBS_CMD_PROG, 1'b1, 20'h01000, 32'h1234_5678);
        fin(3'h1);
        go(`CFBS_CMD_PROG, 1'b1, 20'h010c0, 32'hc0c0_0001);
        fin(3'h1);
        go(`CFBS_CMD_PROG, 1'b1, 20'h000c0, 32'hc0c0_0001);
        fin(3'h1);
        go(`CFBS_CMD_SECURITY, 1'b1, 20'h0, 32'h8);
        fin(3'h1);
        rd("security", `CFBS_OFS_SECURITY, 32'h8, 1'b0);
        rd("status", `CFBS_OFS_STATUS, 32'h0, 1'b0);
        fetch(20'h000c0, 20'h000c0, 1'b0);
        do_reset;
        rd("status", `CFBS_OFS_STATUS, 32'h4, 1'b0);
        fetch(20'h000c0, 20'h010c0, 1'b0);
        fetch(20'h01004, 20'h00004, 1'b0);
        fetch(20'h02000, 20'h02000, 1'b0);
        $display("TB: boot swap done");
        wr(`CFBS_OFS_WINDOW, 32'h001f_0008);
        go(`CFBS_CMD_ERASE, 1'b1, 20'h08000, 32'h0);
        fin(3'h2);
        go(`CFBS_CMD_PROG, 1'b1, 20'h01ffc, 32'h1);
        fin(3'h2);
        go(`CFBS_CMD_ERASE, 1'b1, 20'h02000, 32'h0);
        fin(3'h1);
        go(`CFBS_CMD_ERASE, 1'b0, 20'h08000, 32'h0);
        fin(3'h1);
        chk("array ops", n_ops, 32'd11);
        $display("TB: shield window done");
        stop_test;
    end
endmodule // testbench
